// ---- adcrb_top.sv ----
// adcrb_top: adc result register bank with compare criteria and interrupt
// assumes sequencer results and processor strobes are synchronous to clk_i
//
// How it works
// - new result sets its stored flag
// - reading low byte clears stored flag
// - result before both bytes read sets overrun
// - reading low byte clears overrun flag
// - low byte bits five to two read zero
// - high byte shows result bits nine to two
// - low byte bits seven, six hold result lsbs
// - separate priority pair with own flags
// - criterion 0 pair and criterion 1 low byte writable, reset zero
// - priority results go only to priority pair
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module adcrb_top (
	// clock and reset
	input  wire logic                     clk_i,
	input  wire logic                     reset_i,
	// processor register port
	input  wire adcrb_pkg::adcrb_bus_t    bus_i,
	output logic                    [7:0] rdata_o,
	// sequencer result port
	input  wire adcrb_pkg::adcrb_result_t result_i,
	// criteria to the monitor
	output logic                    [9:0] crit0_o,
	output logic                    [9:0] crit1_o,
	// interrupt
	output logic                          irq_o
);
	logic [7:0]                     low_w   [adcrb_pkg::NUM_SLOTS];
	logic [7:0]                     high_w  [adcrb_pkg::NUM_SLOTS];
	logic [adcrb_pkg::NUM_SLOTS-1:0] load_w;
	logic [adcrb_pkg::NUM_SLOTS-1:0] rdl_w;
	logic [adcrb_pkg::NUM_SLOTS-1:0] rdh_w;
	logic [adcrb_pkg::NUM_SLOTS-1:0] ovr_w;
	logic [9:0]                     crit0_r;
	logic [9:0]                     crit1_r;
	logic [7:0]                     rdata_r;
	logic [5:0]                     irq_st_r;
	logic [5:0]                     irq_mask_r;
	logic                           irq_r;

	function automatic logic [15:0] low_addr(input int s);
		logic [15:0] a;
		a = adcrb_pkg::OFF_CHAN1_LOW + 16'(2 * s);
		if (s == adcrb_pkg::PRIO_SLOT) begin
			a = adcrb_pkg::OFF_PRIO_LOW;
		end
		return a;
	endfunction : low_addr

	wire [15:0] a_w = bus_i.addr;
	wire        rd_w = bus_i.rd;
	wire        wr_w = bus_i.wr;
	wire        prio_w = result_i.valid & result_i.prio;
	wire        norm_w = result_i.valid & ~result_i.prio;

	genvar g;
	generate
		for (g = 0; g < adcrb_pkg::NUM_SLOTS; g++) begin : g_slot
			if (g == adcrb_pkg::PRIO_SLOT) begin : g_p
				assign load_w[g] = prio_w;
			end else begin : g_c
				// channel g+1; never on priority results
				assign load_w[g] = norm_w & (result_i.chan == 3'(g + 1));
			end
			assign rdl_w[g] = rd_w & (a_w == low_addr(g));
			assign rdh_w[g] = rd_w & (a_w == low_addr(g) + 16'h0001);
			adcrb_slot u_slot (
				.clk_i        (clk_i),
				.reset_i      (reset_i),
				.load_i       (load_w[g]),
				.data_i       (result_i.data),
				.rd_low_i     (rdl_w[g]),
				.rd_high_i    (rdh_w[g]),
				.low_o        (low_w[g]),
				.high_o       (high_w[g]),
				.overrun_ev_o (ovr_w[g])
			);
		end
	endgenerate

	// criterion writes; monitor disable is software's duty
	wire wc0l_w = wr_w & (a_w == adcrb_pkg::OFF_CRIT0_LOW);
	wire wc0h_w = wr_w & (a_w == adcrb_pkg::OFF_CRIT0_HIGH);
	wire wc1l_w = wr_w & (a_w == adcrb_pkg::OFF_CRIT1_LOW);
	wire wst_w  = wr_w & (a_w == adcrb_pkg::OFF_IRQ_STATUS);
	wire wmk_w  = wr_w & (a_w == adcrb_pkg::OFF_IRQ_MASK);

	wire [9:0] crit0_nxt = {wc0h_w ? bus_i.wdata : crit0_r[9:2],
	                        wc0l_w ? bus_i.wdata[7:6] : crit0_r[1:0]};
	wire [9:0] crit1_nxt = {crit1_r[9:2], wc1l_w ? bus_i.wdata[7:6] : crit1_r[1:0]};

	// overrun events are sticky; set wins over write-one clear
	wire [5:0] clr_w      = wst_w ? bus_i.wdata[5:0] : 6'h00;
	wire [5:0] irq_st_nxt = ovr_w | (irq_st_r & ~clr_w);
	wire [5:0] mask_nxt   = wmk_w ? bus_i.wdata[5:0] : irq_mask_r;
	wire       irq_nxt    = |(irq_st_nxt & mask_nxt);

	logic [7:0] rd_nxt;
	always_comb begin
		rd_nxt = adcrb_pkg::RESET_BYTE;
		for (int s = 0; s < adcrb_pkg::NUM_SLOTS; s++) begin
			if (rdl_w[s]) begin
				rd_nxt = low_w[s];
			end
			if (rdh_w[s]) begin
				rd_nxt = high_w[s];
			end
		end
		if (rd_w) begin
			unique case (a_w)
				adcrb_pkg::OFF_CRIT0_LOW: begin
					rd_nxt = {crit0_r[1:0], 6'h00};
				end
				adcrb_pkg::OFF_CRIT0_HIGH: begin
					rd_nxt = crit0_r[9:2];
				end
				adcrb_pkg::OFF_CRIT1_LOW: begin
					rd_nxt = {crit1_r[1:0], 6'h00};
				end
				adcrb_pkg::OFF_IRQ_STATUS: begin
					rd_nxt = {2'h0, irq_st_r};
				end
				adcrb_pkg::OFF_IRQ_MASK: begin
					rd_nxt = {2'h0, irq_mask_r};
				end
				default: begin
				end
			endcase
		end
		if (!rd_w) begin
			rd_nxt = adcrb_pkg::RESET_BYTE;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			crit0_r    <= adcrb_pkg::RESET_RESULT;
			crit1_r    <= adcrb_pkg::RESET_RESULT;
			rdata_r    <= adcrb_pkg::RESET_BYTE;
			irq_st_r   <= adcrb_pkg::RESET_IRQ;
			irq_mask_r <= adcrb_pkg::RESET_IRQ;
			irq_r      <= 1'b0;
		end else begin
			crit0_r    <= crit0_nxt;
			crit1_r    <= crit1_nxt;
			rdata_r    <= rd_nxt;
			irq_st_r   <= irq_st_nxt;
			irq_mask_r <= mask_nxt;
			irq_r      <= irq_nxt;
		end
	end

	assign rdata_o = rdata_r;
	assign crit0_o = crit0_r;
	assign crit1_o = crit1_r;
	assign irq_o   = irq_r;
endmodule : adcrb_top
`default_nettype wire

// ---- adcrb_pkg.sv ----
// adcrb_pkg: offsets, field positions, reset values and carrier types for the adc result bank
// assumes byte-wide registers on a plain strobe port with 16-bit addresses
package adcrb_pkg;
	localparam int          ADDR_W          = 16;
	localparam int          DATA_W          = 8;
	localparam int          RES_W           = 10;
	localparam int          NUM_SLOTS       = 6;
	localparam int          PRIO_SLOT       = 5;
	localparam int          NUM_IRQ         = 6;
	// channel pairs 1..5 are slots 0..4, priority pair is slot 5
	localparam logic [15:0] OFF_CHAN1_LOW   = 16'h12a2;
	localparam logic [15:0] OFF_CHAN1_HIGH  = 16'h12a3;
	localparam logic [15:0] OFF_CHAN2_LOW   = 16'h12a4;
	localparam logic [15:0] OFF_CHAN2_HIGH  = 16'h12a5;
	localparam logic [15:0] OFF_CHAN3_LOW   = 16'h12a6;
	localparam logic [15:0] OFF_CHAN3_HIGH  = 16'h12a7;
	localparam logic [15:0] OFF_CHAN4_LOW   = 16'h12a8;
	localparam logic [15:0] OFF_CHAN4_HIGH  = 16'h12a9;
	localparam logic [15:0] OFF_CHAN5_LOW   = 16'h12aa;
	localparam logic [15:0] OFF_CHAN5_HIGH  = 16'h12ab;
	localparam logic [15:0] OFF_PRIO_LOW    = 16'h12b0;
	localparam logic [15:0] OFF_PRIO_HIGH   = 16'h12b1;
	localparam logic [15:0] OFF_CRIT0_LOW   = 16'h12b4;
	localparam logic [15:0] OFF_CRIT0_HIGH  = 16'h12b5;
	localparam logic [15:0] OFF_CRIT1_LOW   = 16'h12b6;
	localparam logic [15:0] OFF_IRQ_STATUS  = 16'h12c0;
	localparam logic [15:0] OFF_IRQ_MASK    = 16'h12c1;
	// low byte layout
	localparam int          BIT_STORED      = 0;
	localparam int          BIT_OVERRUN     = 1;
	localparam int          LOW_RES_LSB     = 6;
	localparam logic [7:0]  RESET_BYTE      = 8'h00;
	localparam logic [9:0]  RESET_RESULT    = 10'h000;
	localparam logic [1:0]  RESET_CRIT_LOW  = 2'h0;
	localparam logic [5:0]  RESET_IRQ       = 6'h00;
	// result written by the sequencer
	typedef struct packed {
		logic       valid;
		logic       prio;
		logic [2:0] chan;
		logic [9:0] data;
	} adcrb_result_t;
	// processor register access
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} adcrb_bus_t;
endpackage : adcrb_pkg

// ---- adcrb_slot.sv ----
// adcrb_slot: one result pair with stored and overrun flags
// assumes read pulses are single-cycle and aligned with the bus strobe
`timescale 1ns/10ps
`default_nettype none
module adcrb_slot (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	// result in
	input  wire logic       load_i,
	input  wire logic [9:0] data_i,
	// processor reads
	input  wire logic       rd_low_i,
	input  wire logic       rd_high_i,
	// state out
	output logic      [7:0] low_o,
	output logic      [7:0] high_o,
	output logic            overrun_ev_o
);
	logic [9:0] data_r;
	logic       stored_r;
	logic       over_r;
	logic       low_seen_r;
	logic       high_seen_r;
	wire        unread_w  = ~(low_seen_r & high_seen_r);
	wire        over_ev_w = load_i & unread_w;
	// hardware set wins over read clear
	wire        stored_nxt = load_i | (stored_r & ~rd_low_i);
	wire        over_nxt   = over_ev_w | (over_r & ~rd_low_i);
	wire        lseen_nxt  = ~load_i & (low_seen_r | rd_low_i);
	wire        hseen_nxt  = ~load_i & (high_seen_r | rd_high_i);
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			data_r      <= adcrb_pkg::RESET_RESULT;
			stored_r    <= 1'b0;
			over_r      <= 1'b0;
			low_seen_r  <= 1'b1;
			high_seen_r <= 1'b1;
		end else begin
			if (load_i) begin
				data_r <= data_i;
			end
			stored_r    <= stored_nxt;
			over_r      <= over_nxt;
			low_seen_r  <= lseen_nxt;
			high_seen_r <= hseen_nxt;
		end
	end
	assign low_o        = {data_r[1:0], 4'h0, over_r, stored_r};
	assign high_o       = data_r[9:2];
	assign overrun_ev_o = over_ev_w;
endmodule : adcrb_slot
`default_nettype wire

// ---- adcrb_top_asserts.sv ----
// adcrb_top_asserts: port timing checks for the adc result bank
// assumes adcrb_top ports, one clock, async active-high reset
`timescale 1ns/10ps
`default_nettype none
module adcrb_top_asserts (
	// watched ports
	input wire logic                     clk_i,
	input wire logic                     reset_i,
	input wire adcrb_pkg::adcrb_bus_t    bus_i,
	input wire logic               [7:0] rdata_o,
	input wire adcrb_pkg::adcrb_result_t result_i,
	input wire logic               [9:0] crit0_o,
	input wire logic               [9:0] crit1_o,
	input wire logic                     irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	sequence nw_s; result_i.valid && !result_i.prio && result_i.chan == 3'h1; endsequence
	sequence rl_s; bus_i.rd && bus_i.addr == adcrb_pkg::OFF_CHAN1_LOW; endsequence
	sequence rh_s; bus_i.rd && bus_i.addr == adcrb_pkg::OFF_CHAN1_HIGH; endsequence
	store_set_a: assert property (nw_s ##1 rl_s |=> rdata_o[0])
		else $error("stored flag not set");
	flags_clear_a: assert property (
		(rl_s and !result_i.valid) ##1 !result_i.valid [*3]
		##1 (rl_s and !result_i.valid) |=> rdata_o[1:0] == 2'h0)
		else $error("flags not cleared by read");
	overrun_set_a: assert property (
		nw_s ##1 !bus_i.rd ##1 (nw_s and !bus_i.rd)
		##1 (rl_s and !result_i.valid) |=> rdata_o[1:0] == 2'h3)
		else $error("overrun not set");
	low_zero_a: assert property (rl_s |=> rdata_o[5:2] == 4'h0)
		else $error("low byte middle bits not zero");
	high_data_a: assert property (nw_s ##1 (rh_s and !result_i.valid)
		|=> rdata_o == $past(result_i.data[9:2], 2))
		else $error("high byte wrong");
	low_data_a: assert property (nw_s ##1 (rl_s and !result_i.valid)
		|=> rdata_o[7:6] == $past(result_i.data[1:0], 2))
		else $error("low byte result bits wrong");
	prio_data_a: assert property (
		(result_i.valid && result_i.prio) ##1 (bus_i.rd
		&& bus_i.addr == adcrb_pkg::OFF_PRIO_HIGH && !result_i.valid)
		|=> rdata_o == $past(result_i.data[9:2], 2))
		else $error("priority high byte wrong");
	crit0_wr_a: assert property (
		bus_i.wr && bus_i.addr == adcrb_pkg::OFF_CRIT0_HIGH
		|=> crit0_o[9:2] == $past(bus_i.wdata))
		else $error("criterion 0 high not written");
	crit1_wr_a: assert property (
		bus_i.wr && bus_i.addr == adcrb_pkg::OFF_CRIT1_LOW
		|=> crit1_o[1:0] == $past(bus_i.wdata[7:6]))
		else $error("criterion 1 low not written");
endmodule : adcrb_top_asserts
bind adcrb_top adcrb_top_asserts i_adcrb_top_asserts (.clk_i(clk_i), .reset_i(reset_i),
	.bus_i(bus_i), .rdata_o(rdata_o), .result_i(result_i), .crit0_o(crit0_o),
	.crit1_o(crit1_o), .irq_o(irq_o));
`default_nettype wire

// ---- adcrb_seq_model.sv ----
// adcrb_seq_model: conversion sequencer delivering one result per request
// assumes requests come from the bench on clk_i
`timescale 1ns/10ps
`default_nettype none
module adcrb_seq_model (
	// clock and reset
	input  wire logic                     clk_i,
	input  wire logic                     reset_i,
	// request
	input  wire logic                     go_i,
	input  wire logic                     prio_i,
	input  wire logic               [2:0] chan_i,
	input  wire logic               [9:0] data_i,
	// result out
	output var adcrb_pkg::adcrb_result_t  res_o
);
	// idle data toggles so no stale value looks valid
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) res_o <= '0;
		else if (go_i) res_o <= '{1'b1, prio_i, chan_i, data_i};
		else res_o <= '{1'b0, 1'b0, 3'h0, ~res_o.data};
	end
endmodule : adcrb_seq_model
`default_nettype wire

// ---- adcrb_top_bench.sv ----
// adcrb_top_bench: self-checking bench for the adc result bank
// assumes adcrb_top, adcrb_seq_model and the checker are compiled before
`timescale 1ns/10ps
`default_nettype none
module adcrb_top_bench;
	logic clk, reset, go, prio, irq;
	logic [2:0] chan;
	logic [9:0] data, crit0, crit1, d;
	logic [7:0] rdata;
	adcrb_pkg::adcrb_bus_t bus;
	adcrb_pkg::adcrb_result_t res;
	int err_count, tests_run, cyc;
	adcrb_top i_adcrb_top (.clk_i(clk), .reset_i(reset), .bus_i(bus), .rdata_o(rdata),
		.result_i(res), .crit0_o(crit0), .crit1_o(crit1), .irq_o(irq));
	adcrb_seq_model i_adcrb_seq_model (.clk_i(clk), .reset_i(reset), .go_i(go),
		.prio_i(prio), .chan_i(chan), .data_i(data), .res_o(res));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge clk) bus <= '{a, v, 1'b1, 1'b0};
		@(posedge clk) bus <= '0;
	endtask : wr
	task automatic rdc(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk) bus <= '0;
		#1 chk({2'h0, rdata}, {2'h0, e});
	endtask : rdc
	task automatic cv(input logic p, input logic [2:0] c, input logic [9:0] v);
		@(posedge clk) {go, prio, chan, data} <= {1'b1, p, c, v};
		@(posedge clk) go <= 1'b0;
	endtask : cv
	task automatic stop_test;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : stop_test
	task automatic t_reset;
		for (int a = 16'h12a2; a <= 16'h12c1; a++) rdc(a[15:0], 8'h00);
		chk(crit0 | crit1, 10'h000);
		$display("t_reset done");
	endtask : t_reset
	task automatic t_store;
		logic [15:0] lo;
		for (int s = 0; s < 6; s++) begin
			d = 10'h2c5 ^ 10'(s * 59);
			lo = (s < 5) ? 16'(16'h12a2 + 2 * s) : adcrb_pkg::OFF_PRIO_LOW;
			cv(s == 5, (s < 5) ? 3'(s + 1) : 3'h1, d);
			rdc(lo, {d[1:0], 6'h01});
			rdc(lo + 16'h1, d[9:2]);
			rdc(lo, {d[1:0], 6'h00});
		end
		rdc(adcrb_pkg::OFF_CHAN1_HIGH, 8'hb1);
		$display("t_store done");
	endtask : t_store
	task automatic t_over;
		wr(adcrb_pkg::OFF_IRQ_MASK, 8'h01);
		cv(1'b0, 3'h1, 10'h3a5);
		cv(1'b0, 3'h1, 10'h0f2);
		rdc(adcrb_pkg::OFF_CHAN1_LOW, 8'h83);
		rdc(adcrb_pkg::OFF_CHAN1_HIGH, 8'h3c);
		rdc(adcrb_pkg::OFF_CHAN1_LOW, 8'h80);
		cv(1'b0, 3'h1, 10'h1d7);
		rdc(adcrb_pkg::OFF_CHAN1_HIGH, 8'h75);
		cv(1'b1, 3'h0, 10'h2b9);
		rdc(adcrb_pkg::OFF_PRIO_HIGH, 8'hae);
		chk({9'h0, irq}, 10'h001);
		wr(adcrb_pkg::OFF_IRQ_STATUS, 8'h01);
		@(posedge clk) #1 chk({9'h0, irq}, 10'h000);
		cv(1'b0, 3'h2, 10'h111);
		rdc(adcrb_pkg::OFF_CHAN2_HIGH, 8'h44);
		cv(1'b0, 3'h2, 10'h2c2);
		rdc(adcrb_pkg::OFF_CHAN2_LOW, 8'h83);
		chk({9'h0, irq}, 10'h000);
		rdc(adcrb_pkg::OFF_IRQ_STATUS, 8'h02);
		wr(adcrb_pkg::OFF_IRQ_STATUS, 8'h02);
		rdc(adcrb_pkg::OFF_IRQ_STATUS, 8'h00);
		$display("t_over done");
	endtask : t_over
	task automatic t_crit;
		wr(adcrb_pkg::OFF_CRIT0_LOW, 8'hc0);
		wr(adcrb_pkg::OFF_CRIT0_HIGH, 8'h5a);
		wr(adcrb_pkg::OFF_CRIT1_LOW, 8'h40);
		#1 chk(crit0, 10'h16b);
		chk(crit1, 10'h001);
		rdc(adcrb_pkg::OFF_CRIT0_HIGH, 8'h5a);
		$display("t_crit done");
	endtask : t_crit
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			stop_test();
		end
	end
	initial begin
		reset = 1'b1;
		bus = '0;
		{go, prio, chan, data} = '0;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		t_reset();
		t_store();
		t_over();
		t_crit();
		stop_test();
	end
endmodule : adcrb_top_bench
`default_nettype wire
